// *** src/bcl_defs.svh ***
// constants for the boot strap configuration loader
// assumes a 10 MHz system clock and straps given as ADC ratio codes in hundredths
`ifndef BCL_DEFS_SVH
`define BCL_DEFS_SVH
`define BCL_SYS_CLK_HZ   10000000
`define BCL_SPI_CLK_HZ   12000000
`define BCL_SPI_HALF_CYC (((`BCL_SYS_CLK_HZ / (2 * `BCL_SPI_CLK_HZ)) > 0) ? \
                          (`BCL_SYS_CLK_HZ / (2 * `BCL_SPI_CLK_HZ)) : 1)
`define BCL_SPI_BITS     56
`define BCL_RX_BITS      24
`define BCL_RX_LAT       3
`define BCL_CMD_READ     8'h03
`define BCL_IMG_ADDR     24'h000000
`define BCL_IMG_MARKER   8'ha5
`define BCL_SETTLE_CYC   8
`define BCL_RETRY_CYC    16
`define BCL_CNT_W        5
`define BCL_ADDR_HI      4'h4
`define BCL_CFGB_INT     0
`define BCL_CFGB_EXT     1
`define BCL_CFGB_PORTS   2
`define BCL_RX_MARKER    23:16
`define BCL_RX_PATCH     15:8
`define BCL_RX_CONFIG    7:0
`define BCL_R010         7'h0a
`define BCL_R020         7'h14
`define BCL_R030         7'h1e
`define BCL_R040         7'h28
`define BCL_R050         7'h32
`define BCL_R060         7'h3c
`define BCL_R070         7'h46
`define BCL_R080         7'h50
`define BCL_R090         7'h5a
`endif

// *** src/bcl_pkg.sv ***
// types for the boot strap configuration loader
// assumes nothing beyond the defs header
package bcl_pkg;
  typedef enum logic [5:0] {
    BCL_NO_RESPONSE_MODE          = 6'h01,
    BCL_WAIT_3V3_INTERNAL_MODE    = 6'h02,
    BCL_CONTROLLER_WAIT_INT_MODE  = 6'h04,
    BCL_WAIT_3V3_EXTERNAL_MODE    = 6'h08,
    BCL_CONTROLLER_WAIT_EXT_MODE  = 6'h10,
    BCL_NO_WAIT_MODE              = 6'h20
  } bcl_mode_e;
  typedef enum logic [7:0] {
    BCL_CFG_SAFE = 8'h01, BCL_CFG_INF_WAIT = 8'h02, BCL_CFG_SET1 = 8'h04,
    BCL_CFG_SET2 = 8'h08, BCL_CFG_SET3 = 8'h10, BCL_CFG_SET4 = 8'h20,
    BCL_CFG_SET5 = 8'h40, BCL_CFG_RSVD = 8'h80
  } bcl_cfg_e;
  typedef enum logic [6:0] {
    BCL_ST_SETTLE = 7'h01, BCL_ST_DECODE = 7'h02, BCL_ST_GATE = 7'h04,
    BCL_ST_LOAD = 7'h08, BCL_ST_XFER = 7'h10, BCL_ST_RETRY = 7'h20,
    BCL_ST_DONE = 7'h40
  } bcl_state_e;
  typedef enum logic [2:0] {
    BCL_SPI_IDLE = 3'h1, BCL_SPI_SHIFT = 3'h2, BCL_SPI_DRAIN = 3'h4
  } bcl_spi_e;
endpackage : bcl_pkg

// *** src/bcl_spi_ctrl.sv ***
// spi mode 0 controller: one fixed read frame per go pulse
// assumes miso_sync is already two-flop synchronised by the caller
`include "bcl_defs.svh"
module bcl_spi_ctrl
  import bcl_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // request
  input  wire logic                      go,
  input  wire logic [`BCL_SPI_BITS-1:0]  tx_frame,
  input  wire logic                      miso_sync,
  // flash pins
  output logic                           sck,
  output logic                           cs_n,
  output logic                           mosi,
  // answer
  output logic                           done,
  output logic [`BCL_RX_BITS-1:0]        rx_data
);
  bcl_spi_e                     st_ff;
  logic [`BCL_SPI_BITS-1:0]     sh_ff;
  logic [5:0]                   bit_ff;
  logic [3:0]                   div_ff;
  logic [`BCL_RX_LAT-1:0]       rise_ff;
  logic                         sck_ff, cs_n_ff, mosi_ff, done_ff;
  logic [`BCL_RX_BITS-1:0]      rx_ff;
  logic                         half_end, rise;

  assign half_end = (div_ff == 4'(`BCL_SPI_HALF_CYC - 1));
  assign rise     = (st_ff == BCL_SPI_SHIFT) && half_end && !sck_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff   <= BCL_SPI_IDLE;
      cs_n_ff <= 1'b1;
      sck_ff  <= 1'b0;
      mosi_ff <= 1'b0;
      sh_ff   <= '0;
      bit_ff  <= 6'h00;
      div_ff  <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        BCL_SPI_IDLE: if (go) begin
          cs_n_ff <= 1'b0; // R5
          mosi_ff <= tx_frame[`BCL_SPI_BITS-1]; // R6
          sh_ff   <= {tx_frame[`BCL_SPI_BITS-2:0], 1'b0};
          bit_ff  <= 6'h00;
          div_ff  <= 4'h0;
          st_ff   <= BCL_SPI_SHIFT;
        end
        BCL_SPI_SHIFT: if (half_end) begin
          div_ff <= 4'h0;
          if (!sck_ff) begin
            sck_ff <= 1'b1; // R4
          end else begin
            sck_ff <= 1'b0; // R8
            if (bit_ff == 6'(`BCL_SPI_BITS - 1)) begin
              st_ff <= BCL_SPI_DRAIN;
            end else begin
              bit_ff  <= bit_ff + 6'h01;
              mosi_ff <= sh_ff[`BCL_SPI_BITS-1]; // R7
              sh_ff   <= {sh_ff[`BCL_SPI_BITS-2:0], 1'b0};
            end
          end
        end else begin
          div_ff <= div_ff + 4'h1;
        end
        BCL_SPI_DRAIN: if (rise_ff == '0) begin
          cs_n_ff <= 1'b1; // R5
          done_ff <= 1'b1;
          st_ff   <= BCL_SPI_IDLE;
        end
        default: st_ff <= BCL_SPI_IDLE;
      endcase
    end
  end

  // capture a bit once the synchroniser has caught up with the rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_ff <= '0;
      rx_ff   <= '0;
    end else begin
      rise_ff <= {rise_ff[`BCL_RX_LAT-2:0], rise};
      if (rise_ff[`BCL_RX_LAT-1]) begin
        rx_ff <= {rx_ff[`BCL_RX_BITS-2:0], miso_sync}; // R7
      end
    end
  end

  assign sck     = sck_ff;
  assign cs_n    = cs_n_ff;
  assign mosi    = mosi_ff;
  assign done    = done_ff;
  assign rx_data = rx_ff;

  a_cs_first_bit: assert property (@(posedge clk) disable iff (!rst_n) // R6
    $fell(cs_n_ff) |-> (mosi_ff == tx_frame[`BCL_SPI_BITS-1]) && !sck_ff)
    else $error("first bit not present with chip select");
  a_sck_idle_low: assert property (@(posedge clk) disable iff (!rst_n) // R8
    cs_n_ff |-> !sck_ff) else $error("serial clock not low while idle");
  a_mode0_edges: assert property (@(posedge clk) disable iff (!rst_n) // R7
    sck_ff |-> $stable(mosi_ff)) else $error("data changed while clock high");
  a_sck_rate: assert property (@(posedge clk) disable iff (!rst_n) // R4
    $rose(sck_ff) |=> $fell(sck_ff)) else $error("serial clock high too long");
  a_cs_frame: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (st_ff == BCL_SPI_SHIFT) |-> !cs_n_ff) else $error("chip select high mid frame");
  c_frame_done: cover property (@(posedge clk) disable iff (!rst_n) done_ff);
endmodule : bcl_spi_ctrl

// *** src/bcl_boot_loader.sv ***
// boot strap configuration loader: straps, address select, flash image fetch
// assumes strap pins are static during boot and ADC codes are ratios in hundredths
//
// Overview of operation
// (R1) decode address divider into three select bits
// (R2) select bits go to address bits 3:1
// (R3) boot fetches patch and config from flash
// (R4) flash serial clock derived from 12 MHz target; the code runs it at 5 MHz, half the 10 MHz system clock
// (R5) spi mode 0, chip select low per frame
// (R6) first data bit with chip select assertion
// (R7) shift on falling edge, sample on rising
// (R8) serial clock idles low
// (R9) flash holds 64 kB, 4 KB sectors
// (R10) power-on boot routine loads patch and config
// (R11) straps pick one table entry
// (R12) strap high ratio table selection
// (R13) strap low ratio table selection
// (R14) dead-battery mode only when bus powered
// (R15) no-response: no switch, wait for 3.3 V
// (R16) internal modes enable internal switch
// (R17) external modes enable external switch
// (R18) wait modes hold until 3.3 V present
// (R19) controller-wait retries loading forever
// (R20) no-wait loads while only bus powered
// (R21) no-wait closes switch from loaded config
// (R22) address is 0100, select bits, rw
// (R23) config from flash or i2c path
// (R24) no config found uses strap default
// (R25) safe disables ports, infinite wait stays
// (R26) straps sampled once, held until reset
`include "bcl_defs.svh"
module bcl_boot_loader
  import bcl_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // supplies
  input  wire logic        VBUS_PRESENT,
  input  wire logic        EXTERNAL_3V3_SUPPLY_OK,
  // strap adc codes
  input  wire logic [6:0]  BOOT_STRAP_ADC_PIN,
  input  wire logic [6:0]  ADDR_SELECT_ADC_PIN,
  // flash link
  input  wire logic        FLASH_DATA_IN_STRAP,
  output logic             FLASH_SCK,
  output logic             FLASH_CS_N,
  output logic             FLASH_DATA_OUT,
  // configuration over i2c host path
  input  wire logic        I2C_CFG_VALID,
  input  wire logic [7:0]  I2C_CFG_DATA,
  // results
  output logic [7:0]       I2C_ADDR,
  output logic [5:0]       DB_MODE,
  output logic [7:0]       DEF_CFG,
  output logic             INT_SW_EN,
  output logic             EXT_SW_EN,
  output logic             PORTS_EN,
  output logic             LEGACY_SINK,
  output logic             BOOT_DONE,
  output logic             CFG_LOADED,
  output logic [7:0]       CFG_DATA,
  output logic [7:0]       PATCH_DATA
);
  localparam int RETRY_MAX = `BCL_RETRY_CYC + 2;

  function automatic logic [3:0] bcl_band(input logic [6:0] c);
    logic [3:0] b;
    b = 4'h0;
    if (c >= `BCL_R010) b = 4'h1;
    if (c >= `BCL_R020) b = 4'h2;
    if (c >= `BCL_R030) b = 4'h3;
    if (c >= `BCL_R040) b = 4'h4;
    if (c >= `BCL_R050) b = 4'h5;
    if (c >= `BCL_R060) b = 4'h6;
    if (c >= `BCL_R070) b = 4'h7;
    if (c >= `BCL_R080) b = 4'h8;
    if (c >= `BCL_R090) b = 4'h9;
    return b;
  endfunction : bcl_band

  function automatic logic [2:0] bcl_addr_dec(input logic [6:0] c);
    logic [2:0] a;
    a = 3'h0;
    if (c >= `BCL_R020) a = 3'h1;
    if (c >= `BCL_R040) a = 3'h2;
    if (c >= `BCL_R060) a = 3'h3;
    return a;
  endfunction : bcl_addr_dec

  logic [6:0]  boot_m1, boot_m2, addr_m1, addr_m2;
  logic [2:0]  pin_m1, pin_m2;
  logic        vbus_s, v3_s, miso_s, bus_only;
  bcl_state_e  st_ff;
  logic [`BCL_CNT_W-1:0] cnt_ff;
  bcl_mode_e   mode_ff, nxt_mode;
  bcl_cfg_e    def_ff, nxt_def;
  logic [7:0]  addr_ff, cfg_ff, patch_ff;
  logic        loaded_ff, go_ff, int_ff, ext_ff, ports_ff, legacy_ff, done_ff;
  logic        spi_done, marker_ok, def_ports, int_mode, ext_mode, wait_mode;
  logic [`BCL_RX_BITS-1:0] rx;

  // two-flop synchronisers for every pin except the i2c configuration inputs
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_m1  <= 3'h0;
      pin_m2  <= 3'h0;
      boot_m1 <= 7'h00;
      boot_m2 <= 7'h00;
      addr_m1 <= 7'h00;
      addr_m2 <= 7'h00;
    end else begin
      pin_m1  <= {VBUS_PRESENT, EXTERNAL_3V3_SUPPLY_OK, FLASH_DATA_IN_STRAP};
      pin_m2  <= pin_m1;
      boot_m1 <= BOOT_STRAP_ADC_PIN;
      boot_m2 <= boot_m1;
      addr_m1 <= ADDR_SELECT_ADC_PIN;
      addr_m2 <= addr_m1;
    end
  end

  assign vbus_s    = pin_m2[2];
  assign v3_s      = pin_m2[1];
  assign miso_s    = pin_m2[0];
  assign bus_only  = vbus_s && !v3_s; // R14
  assign marker_ok = (rx[`BCL_RX_MARKER] == `BCL_IMG_MARKER);
  assign int_mode  = (mode_ff == BCL_WAIT_3V3_INTERNAL_MODE) ||
                     (mode_ff == BCL_CONTROLLER_WAIT_INT_MODE);
  assign ext_mode  = (mode_ff == BCL_WAIT_3V3_EXTERNAL_MODE) ||
                     (mode_ff == BCL_CONTROLLER_WAIT_EXT_MODE);
  assign wait_mode = (mode_ff == BCL_NO_RESPONSE_MODE) ||
                     (mode_ff == BCL_WAIT_3V3_INTERNAL_MODE) ||
                     (mode_ff == BCL_WAIT_3V3_EXTERNAL_MODE);
  assign def_ports = (def_ff != BCL_CFG_SAFE) && (def_ff != BCL_CFG_RSVD) &&
                     (def_ff != BCL_CFG_INF_WAIT); // R25

  // strap table lookup
  always_comb begin
    nxt_mode = BCL_NO_RESPONSE_MODE;
    nxt_def  = BCL_CFG_SAFE;
    if (miso_s) begin
      case (bcl_band(boot_m2))
        4'h0, 4'h1: nxt_mode = BCL_NO_RESPONSE_MODE; // R12
        4'h2: nxt_mode = BCL_WAIT_3V3_INTERNAL_MODE; // R12
        4'h3: begin
          nxt_mode = BCL_CONTROLLER_WAIT_INT_MODE; // R12
          nxt_def  = BCL_CFG_INF_WAIT;
        end
        4'h4: nxt_mode = BCL_WAIT_3V3_EXTERNAL_MODE; // R12
        4'h5: begin
          nxt_mode = BCL_CONTROLLER_WAIT_EXT_MODE; // R12
          nxt_def  = BCL_CFG_INF_WAIT;
        end
        default: nxt_mode = BCL_NO_WAIT_MODE; // R12
      endcase
    end else begin
      case (bcl_band(boot_m2))
        4'h1: nxt_def = BCL_CFG_SET1; // R13
        4'h2: nxt_def = BCL_CFG_SET2; // R13
        4'h3: begin
          nxt_mode = BCL_CONTROLLER_WAIT_INT_MODE; // R13
          nxt_def  = BCL_CFG_INF_WAIT;
        end
        4'h4: begin
          nxt_mode = BCL_NO_WAIT_MODE; // R13
          nxt_def  = BCL_CFG_SET3;
        end
        4'h5: begin
          nxt_mode = BCL_CONTROLLER_WAIT_EXT_MODE; // R13
          nxt_def  = BCL_CFG_INF_WAIT;
        end
        4'h6: nxt_def = BCL_CFG_SET4; // R13
        4'h7: begin
          nxt_mode = BCL_NO_WAIT_MODE; // R13
          nxt_def  = BCL_CFG_RSVD;
        end
        4'h8: nxt_def = BCL_CFG_RSVD; // R13
        4'h9: begin
          nxt_mode = BCL_NO_WAIT_MODE; // R13
          nxt_def  = BCL_CFG_SET5;
        end
        default: nxt_def = BCL_CFG_SAFE;
      endcase
    end
  end

  // boot sequence
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff  <= BCL_ST_SETTLE;
      cnt_ff <= '0;
      go_ff  <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      case (st_ff)
        BCL_ST_SETTLE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == `BCL_CNT_W'(`BCL_SETTLE_CYC - 1)) st_ff <= BCL_ST_DECODE; // R10
        end
        BCL_ST_DECODE: st_ff <= BCL_ST_GATE;
        BCL_ST_GATE: if (!(bus_only && wait_mode)) begin
          st_ff <= BCL_ST_LOAD; // R18 R15 R20
        end
        BCL_ST_LOAD: if (I2C_CFG_VALID) begin
          st_ff <= BCL_ST_DONE; // R23
        end else begin
          go_ff <= 1'b1; // R3
          st_ff <= BCL_ST_XFER;
        end
        BCL_ST_XFER: if (spi_done) begin
          cnt_ff <= '0;
          if (marker_ok) st_ff <= BCL_ST_DONE;
          else if (def_ff == BCL_CFG_INF_WAIT) st_ff <= BCL_ST_RETRY; // R19 R25
          else st_ff <= BCL_ST_DONE; // R24
        end
        BCL_ST_RETRY: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == `BCL_CNT_W'(`BCL_RETRY_CYC - 1)) st_ff <= BCL_ST_LOAD; // R19
        end
        BCL_ST_DONE: st_ff <= BCL_ST_DONE;
        default: st_ff <= BCL_ST_SETTLE;
      endcase
    end
  end

  // straps caught once after release of reset
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_ff <= BCL_NO_RESPONSE_MODE;
      def_ff  <= BCL_CFG_SAFE;
      addr_ff <= 8'h00;
    end else if (st_ff == BCL_ST_DECODE) begin
      mode_ff <= nxt_mode; // R11 R26
      def_ff  <= nxt_def; // R11 R26
      addr_ff <= {`BCL_ADDR_HI, bcl_addr_dec(addr_m2), 1'b0}; // R1 R2 R22
    end
  end

  // loaded image
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      loaded_ff <= 1'b0;
      cfg_ff    <= 8'h00;
      patch_ff  <= 8'h00;
    end else if (st_ff == BCL_ST_LOAD && I2C_CFG_VALID) begin
      loaded_ff <= 1'b1; // R23
      cfg_ff    <= I2C_CFG_DATA;
    end else if (st_ff == BCL_ST_XFER && spi_done && marker_ok) begin
      loaded_ff <= 1'b1; // R3 R10
      patch_ff  <= rx[`BCL_RX_PATCH];
      cfg_ff    <= rx[`BCL_RX_CONFIG];
    end
  end

  // power switches and port state
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      int_ff    <= 1'b0;
      ext_ff    <= 1'b0;
      ports_ff  <= 1'b0;
      legacy_ff <= 1'b0;
      done_ff   <= 1'b0;
    end else if (st_ff == BCL_ST_DONE) begin
      done_ff <= 1'b1;
      if (loaded_ff) begin
        int_ff    <= cfg_ff[`BCL_CFGB_INT]; // R21
        ext_ff    <= cfg_ff[`BCL_CFGB_EXT]; // R21
        ports_ff  <= cfg_ff[`BCL_CFGB_PORTS];
        legacy_ff <= 1'b0;
      end else begin
        ports_ff  <= def_ports; // R24
        legacy_ff <= !def_ports && bus_only; // R25
      end
    end else if (st_ff != BCL_ST_SETTLE && st_ff != BCL_ST_DECODE && bus_only) begin
      if (int_mode) int_ff <= 1'b1; // R16
      if (ext_mode) ext_ff <= 1'b1; // R17
    end
  end

  bcl_spi_ctrl u_spi (
    .clk       (CLK_SYS),
    .rst_n     (RESET_N),
    .go        (go_ff),
    .tx_frame  ({`BCL_CMD_READ, `BCL_IMG_ADDR, {`BCL_RX_BITS{1'b0}}}), // R9
    .miso_sync (miso_s),
    .sck       (FLASH_SCK),
    .cs_n      (FLASH_CS_N),
    .mosi      (FLASH_DATA_OUT),
    .done      (spi_done),
    .rx_data   (rx)
  );

  assign I2C_ADDR    = addr_ff;
  assign DB_MODE     = mode_ff;
  assign DEF_CFG     = def_ff;
  assign INT_SW_EN   = int_ff;
  assign EXT_SW_EN   = ext_ff;
  assign PORTS_EN    = ports_ff;
  assign LEGACY_SINK = legacy_ff;
  assign BOOT_DONE   = done_ff;
  assign CFG_LOADED  = loaded_ff;
  assign CFG_DATA    = cfg_ff;
  assign PATCH_DATA  = patch_ff;

  a_addr_decode: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R1
    ($past(st_ff) == BCL_ST_DECODE) |-> (addr_ff[3:1] == bcl_addr_dec($past(addr_m2))))
    else $error("address select decode wrong");
  a_addr_layout: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R22
    (st_ff != BCL_ST_SETTLE && st_ff != BCL_ST_DECODE) |->
      (addr_ff[7:4] == `BCL_ADDR_HI) && !addr_ff[0]) else $error("address layout wrong");
  a_straps_stable: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R26
    (st_ff != BCL_ST_SETTLE && st_ff != BCL_ST_DECODE && $past(st_ff) != BCL_ST_DECODE)
      |-> $stable(mode_ff) && $stable(def_ff)) else $error("strap result changed");
  a_no_resp_sw: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R15
    (mode_ff == BCL_NO_RESPONSE_MODE && !loaded_ff) |-> !int_ff && !ext_ff)
    else $error("switch enabled in no-response mode");
  a_hold_3v3: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R18
    (st_ff == BCL_ST_GATE && bus_only && wait_mode) |=> (st_ff == BCL_ST_GATE) && !go_ff)
    else $error("start-up continued without 3.3 V");
  a_int_switch: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R16
    (st_ff == BCL_ST_GATE && bus_only && int_mode) |=> int_ff && !ext_ff)
    else $error("internal switch not enabled");
  a_ext_switch: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R17
    (st_ff == BCL_ST_GATE && bus_only && ext_mode) |=> ext_ff && !int_ff)
    else $error("external switch not enabled");
  a_retry_forever: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R19
    (st_ff == BCL_ST_XFER && spi_done && !marker_ok && def_ff == BCL_CFG_INF_WAIT)
      |=> (st_ff == BCL_ST_RETRY) ##[1:RETRY_MAX] (st_ff == BCL_ST_LOAD))
    else $error("load not retried");
  a_default_cfg: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R24
    (st_ff == BCL_ST_XFER && spi_done && !marker_ok && def_ff != BCL_CFG_INF_WAIT)
      |=> ##1 done_ff && !loaded_ff && (ports_ff == def_ports))
    else $error("strap default not adopted");
  a_loaded_switch: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R21
    (st_ff == BCL_ST_DONE && loaded_ff) |=>
      (int_ff == cfg_ff[`BCL_CFGB_INT]) && (ext_ff == cfg_ff[`BCL_CFGB_EXT]))
    else $error("loaded switch selection not applied");
  c_flash_loaded: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_ff == BCL_ST_DONE) && loaded_ff);
  c_retry: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    st_ff == BCL_ST_RETRY);
  c_gate_hold: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (st_ff == BCL_ST_GATE) && bus_only && wait_mode);
  c_default: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    done_ff && !loaded_ff);
endmodule : bcl_boot_loader

// *** sim/bcl_flash_model.sv ***
// serial flash model answering the loader's fixed read frame
// assumes a strap resistor holds the data line while the flash is deselected
module bcl_flash_model (
  // flash pins
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             so,
  output logic             so_en,
  // bench side
  input  wire logic        slow,
  input  wire logic [23:0] image,
  output logic [31:0]      cmd,
  output logic             addr_ok,
  output int               rises,
  output int               frames
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MEM_BYTES = 65536;
  initial begin
    so = 1'b0;
    so_en = 1'b0;
    cmd = '0;
    rises = 0;
    frames = 0;
  end
  assign addr_ok = cmd[23:0] < 24'(MEM_BYTES);
  always @(negedge cs_n) begin
    frames++;
    rises = 0;
    so_en = 1'b1;
    so = ~so;
  end
  always @(posedge cs_n) so_en = 1'b0;
  // first rising edge of a frame already carries a command bit
  always @(posedge sck) if (!cs_n) begin
    if (rises < 32) cmd = {cmd[30:0], mosi};
    rises++;
  end
  // outside the read phase the line toggles rather than holding
  always @(negedge sck) if (!cs_n) begin
    #(slow ? 60 : 5);
    so = (rises >= 32 && rises < 56) ? image[55-rises] : ~so;
  end
endmodule : bcl_flash_model

// *** sim/bcl_boot_loader_tb.sv ***
// self-checking bench for the boot strap configuration loader
// assumes the flash model is compiled before this file
module bcl_boot_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic       s;
    logic [6:0] r;
    logic [6:0] a;
    logic [5:0] m;
    logic [7:0] c;
    logic [7:0] ad;
  } bcl_row_s;
  logic        clk;
  logic        rst_n = 1'b0;
  logic        vbus = 1'b0;
  logic        v33 = 1'b0;
  logic        strap = 1'b1;
  logic        i2c_v = 1'b0;
  logic        slow = 1'b0;
  logic [6:0]  boot_r = 7'h00;
  logic [6:0]  addr_r = 7'h00;
  logic [7:0]  i2c_d = 8'h80;
  logic [23:0] image = 24'h000000;
  wire logic   sck, cs_n, mosi, so, so_en, data_in, addr_ok;
  logic [7:0]  i2c_addr, def_cfg, cfg_data, patch;
  logic [5:0]  db_mode;
  logic        int_sw, ext_sw, ports, legacy, done, loaded;
  logic [31:0] cmd;
  int          rises, frames, f0;
  int          error_cnt = 0;
  int          samples_checked = 0;
  bcl_row_s rows [19] = '{
    '{1'b1, 7'h0a, 7'h00, 6'h01, 8'h01, 8'h40}, '{1'b1, 7'h12, 7'h14, 6'h01, 8'h01, 8'h42},
    '{1'b1, 7'h19, 7'h1e, 6'h02, 8'h01, 8'h42}, '{1'b1, 7'h23, 7'h32, 6'h04, 8'h02, 8'h44},
    '{1'b1, 7'h28, 7'h28, 6'h08, 8'h01, 8'h44}, '{1'b1, 7'h2d, 7'h64, 6'h08, 8'h01, 8'h46},
    '{1'b1, 7'h37, 7'h00, 6'h10, 8'h02, 8'h40}, '{1'b1, 7'h50, 7'h1e, 6'h20, 8'h01, 8'h42},
    '{1'b0, 7'h05, 7'h64, 6'h01, 8'h01, 8'h46}, '{1'b0, 7'h0f, 7'h32, 6'h01, 8'h04, 8'h44},
    '{1'b0, 7'h19, 7'h64, 6'h01, 8'h08, 8'h46}, '{1'b0, 7'h23, 7'h00, 6'h04, 8'h02, 8'h40},
    '{1'b0, 7'h2d, 7'h1e, 6'h20, 8'h10, 8'h42}, '{1'b0, 7'h37, 7'h32, 6'h10, 8'h02, 8'h44},
    '{1'b0, 7'h3c, 7'h26, 6'h01, 8'h20, 8'h42}, '{1'b0, 7'h41, 7'h64, 6'h01, 8'h20, 8'h46},
    '{1'b0, 7'h4b, 7'h00, 6'h20, 8'h80, 8'h40}, '{1'b0, 7'h55, 7'h1e, 6'h01, 8'h80, 8'h42},
    '{1'b0, 7'h5f, 7'h32, 6'h20, 8'h40, 8'h44}};
  // strap resistor sets the line whenever the flash lets go
  assign data_in = so_en ? so : strap;
  bcl_boot_loader i_bcl_boot_loader (
    .CLK_SYS(clk), .RESET_N(rst_n), .VBUS_PRESENT(vbus), .EXTERNAL_3V3_SUPPLY_OK(v33),
    .BOOT_STRAP_ADC_PIN(boot_r), .ADDR_SELECT_ADC_PIN(addr_r), .FLASH_DATA_IN_STRAP(data_in),
    .FLASH_SCK(sck), .FLASH_CS_N(cs_n), .FLASH_DATA_OUT(mosi), .I2C_CFG_VALID(i2c_v),
    .I2C_CFG_DATA(i2c_d), .I2C_ADDR(i2c_addr), .DB_MODE(db_mode), .DEF_CFG(def_cfg),
    .INT_SW_EN(int_sw), .EXT_SW_EN(ext_sw), .PORTS_EN(ports), .LEGACY_SINK(legacy),
    .BOOT_DONE(done), .CFG_LOADED(loaded), .CFG_DATA(cfg_data), .PATCH_DATA(patch));
  bcl_flash_model i_bcl_flash_model (
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .so(so), .so_en(so_en), .slow(slow),
    .image(image), .cmd(cmd), .addr_ok(addr_ok), .rises(rises), .frames(frames));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic boot(input logic s, input logic [6:0] r, input logic [6:0] a,
                      input logic vb, input logic v3, input logic iv);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    boot_r <= r;
    addr_r <= a;
    vbus <= vb;
    v33 <= v3;
    i2c_v <= iv;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask : boot
  task automatic wait_done(input int n);
    for (int i = 0; i < n && done !== 1'b1; i++) @(negedge clk);
    samples_checked++;
    if (done !== 1'b1) begin
      error_cnt++;
      $display("FAIL boot_done expected 1 seen %b", done);
      stop_test();
    end
  endtask : wait_done
  always @(negedge clk) if (rst_n === 1'b1 && cs_n === 1'b1) begin
    chk("idle_sck", 32'h0, sck);
  end
  initial begin
    for (int i = 0; i < 19; i++) begin
      boot(rows[i].s, rows[i].r, rows[i].a, 1'b1, 1'b1, 1'b1);
      wait_done(40);
      chk("db_mode", rows[i].m, db_mode);
      chk("def_cfg", rows[i].c, def_cfg);
      chk("i2c_addr", rows[i].ad, i2c_addr);
      chk("cfg_data", 8'h80, cfg_data);
      chk("switches", 2'b00, {int_sw, ext_sw});
    end
    $display("test strap_table done");
    image <= 24'ha55a05;
    slow <= 1'b1;
    boot(1'b1, 7'h50, 7'h00, 1'b1, 1'b0, 1'b0);
    wait_done(400);
    chk("loaded", 1, loaded);
    chk("patch", 8'h5a, patch);
    chk("cfg", 8'h05, cfg_data);
    chk("sw", 3'b101, {ports, ext_sw, int_sw});
    chk("cmd", 32'h03000000, cmd);
    chk("sck_rises", 56, rises);
    chk("addr_ok", 1, addr_ok);
    $display("test flash_load done");
    slow <= 1'b0;
    f0 = frames;
    boot(1'b1, 7'h19, 7'h00, 1'b1, 1'b0, 1'b1);
    repeat (60) @(negedge clk);
    chk("held", 0, done);
    chk("no_frame", f0, frames);
    chk("int_sw", 1, int_sw);
    @(posedge clk) boot_r <= 7'h50;
    repeat (20) @(negedge clk);
    chk("mode_kept", 6'h02, db_mode);
    @(posedge clk) v33 <= 1'b1;
    wait_done(60);
    chk("i2c_cfg", 1, loaded);
    $display("test wait_3v3 done");
    image <= 24'h000000;
    boot(1'b1, 7'h37, 7'h00, 1'b1, 1'b0, 1'b0);
    f0 = frames;
    repeat (600) @(negedge clk);
    chk("never_done", 0, done);
    chk("retried", 1, frames - f0 > 2);
    chk("ext_sw", 2'b10, {ext_sw, int_sw});
    $display("test retry done");
    // reset in the middle of a retry loop returns chip select, serial clock, done, mode, default, address and switches to their idle values
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk("reset_outs", {3'b100, 6'h01, 8'h01, 8'h00, 2'b00},
        {cs_n, sck, done, db_mode, def_cfg, i2c_addr, ext_sw, int_sw});
    $display("test reset done");
    boot(1'b1, 7'h0a, 7'h00, 1'b1, 1'b0, 1'b0);
    repeat (60) @(negedge clk);
    chk("nr_idle", 3'b000, {done, ext_sw, int_sw});
    $display("test no_response done");
    boot(1'b0, 7'h0f, 7'h00, 1'b1, 1'b1, 1'b0);
    wait_done(400);
    chk("fallback", 2'b01, {loaded, ports});
    boot(1'b1, 7'h50, 7'h00, 1'b1, 1'b0, 1'b0);
    wait_done(400);
    chk("safe", 2'b01, {ports, legacy});
    $display("test defaults done");
    stop_test();
  end
endmodule : bcl_boot_loader_tb
